// *** rtl/csic_consts.vh ***
`ifndef CSIC_CONSTS_VH
`define CSIC_CONSTS_VH

// ----------------------------------------
// register index
// ----------------------------------------
`define CSIC_IDX_CTRL 8'h03
`define CSIC_IDX_STAT 8'h04

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSIC_CTRL_RST 8'h00
`define CSIC_STAT_RST 4'h0

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CSIC_RING_EN_BIT 7
`define CSIC_RST_REL_BIT 6
`define CSIC_KIND_BIT 5
`define CSIC_PCI_ROUTE_BIT 4
`define CSIC_SEL_MSB 3
`define CSIC_SEL_LSB 0

// ----------------------------------------
// status field positions
// ----------------------------------------
`define CSIC_DET_BIT 3
`define CSIC_RDY_BIT 2
`define CSIC_LOW_BIT 1
`define CSIC_DEAD_BIT 0

// ----------------------------------------
// line select codes
// ----------------------------------------
`define CSIC_SEL_NONE 4'h0
`define CSIC_SEL_SMI 4'h2
`define CSIC_SMI_MASK 16'h0004

// ----------------------------------------
// battery pair codes, {detect2, detect1}
// ----------------------------------------
`define CSIC_BAT_DEAD0 2'h0
`define CSIC_BAT_DEAD1 2'h1
`define CSIC_BAT_LOW 2'h2

`endif

// *** rtl/csic_top.v ***
`timescale 1ns/100ps
`include "csic_consts.vh"

module csic_top (
	input wire clk,
	input wire rstn,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	input wire [3:0] source_enable,
	input wire [3:0] status_irq_line_select,
	input wire clear_by_write,
	input wire detect_pin_one_n,
	input wire detect_pin_two_n,
	input wire ready_pin,
	input wire battery_detect1_ring_pin,
	input wire battery_detect2_pin,
	input wire card_irq_n,
	output reg card_reset,
	output reg status_pci_irq,
	output reg [15:0] status_legacy_irq,
	output reg [15:0] io_card_irq,
	output reg system_mgmt_interrupt
);

	// ----------------------------------------
	// line decode
	// ----------------------------------------
	// code 2 is the SYSTEM_MGMT_INTERRUPT slot; the numbered vector never carries it
	function [15:0] line_decode;
		input [3:0] sel;
		input active;
		begin
			line_decode = 16'h0000;
			if (active && sel != `CSIC_SEL_NONE) begin
				line_decode[sel] = 1'b1;
			end
		end
	endfunction

	// pair is {detect2, detect1}; both dead codes count as dead
	function bat_dead;
		input [1:0] pair;
		begin
			bat_dead = (pair == `CSIC_BAT_DEAD0) || (pair == `CSIC_BAT_DEAD1);
		end
	endfunction

	function bat_low;
		input [1:0] pair;
		begin
			bat_low = (pair == `CSIC_BAT_LOW);
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// order: det1, det2, ready, bvd1, bvd2, card irq
	// flops reset high, the idle level of every pin, so an empty socket gives no edge
	wire [5:0] pin_raw;
	reg [5:0] pin_meta_reg;
	reg [5:0] pin_sync_reg;
	reg [5:0] pin_prev_reg;

	assign pin_raw = {card_irq_n, battery_detect2_pin, battery_detect1_ring_pin,
		ready_pin, detect_pin_two_n, detect_pin_one_n};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pin_meta_reg[gi] <= 1'b1;
					pin_sync_reg[gi] <= 1'b1;
					pin_prev_reg[gi] <= 1'b1;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
					pin_prev_reg[gi] <= pin_sync_reg[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] ctrl_reg;
	reg [7:0] ctrl_next;
	reg [3:0] flag_reg;
	reg [3:0] flag_next;

	wire ring_en;
	wire io_kind;
	wire [3:0] io_sel;
	// ring use of shared pin
	// for an I/O card, ring use steers status bit 0 and masks the status-change edge
	assign ring_en = ctrl_reg[`CSIC_RING_EN_BIT];
	assign io_kind = ctrl_reg[`CSIC_KIND_BIT];
	assign io_sel = ctrl_reg[`CSIC_SEL_MSB:`CSIC_SEL_LSB];

	// ----------------------------------------
	// source conditions
	// ----------------------------------------
	wire [1:0] bvd_now;
	wire [1:0] bvd_old;
	wire dead_now;
	wire dead_old;
	wire low_now;
	wire low_old;
	wire det_change;
	wire ready_rise;
	wire status_change_pin_assert;
	wire ring_active;

	assign bvd_now = {pin_sync_reg[4], pin_sync_reg[3]};
	assign bvd_old = {pin_prev_reg[4], pin_prev_reg[3]};
	assign dead_now = bat_dead(bvd_now);
	assign dead_old = bat_dead(bvd_old);
	assign low_now = bat_low(bvd_now);
	assign low_old = bat_low(bvd_old);
	assign det_change = (pin_sync_reg[0] ^ pin_prev_reg[0]) |
		(pin_sync_reg[1] ^ pin_prev_reg[1]);
	assign ready_rise = pin_sync_reg[2] & ~pin_prev_reg[2];
	// status change and ring are active low on the shared pin
	assign status_change_pin_assert = ~pin_sync_reg[3] & pin_prev_reg[3];
	assign ring_active = ~pin_sync_reg[3];

	// ----------------------------------------
	// flag update
	// ----------------------------------------
	reg [3:0] flag_set;
	reg [3:0] flag_clr;
	wire [3:0] flag_view;
	wire stat_hit;
	wire ctrl_hit;

	assign stat_hit = (reg_addr == `CSIC_IDX_STAT);
	assign ctrl_hit = (reg_addr == `CSIC_IDX_CTRL);

	always @* begin
		flag_set = 4'h0;
		flag_set[`CSIC_DET_BIT] = source_enable[`CSIC_DET_BIT] & det_change;
		flag_set[`CSIC_RDY_BIT] = source_enable[`CSIC_RDY_BIT] & ~io_kind & ready_rise;
		flag_set[`CSIC_LOW_BIT] = source_enable[`CSIC_LOW_BIT] & ~io_kind &
			low_now & ~low_old;
		if (io_kind) begin
			flag_set[`CSIC_DEAD_BIT] = source_enable[`CSIC_DEAD_BIT] & ~ring_en &
				status_change_pin_assert;
		end else begin
			flag_set[`CSIC_DEAD_BIT] = source_enable[`CSIC_DEAD_BIT] & dead_now & ~dead_old;
		end
		flag_clr = 4'h0;
		// clear by read or by write of one
		if (stat_hit && clear_by_write && reg_wr) begin
			flag_clr = reg_wdata[3:0];
		end else if (stat_hit && !clear_by_write && reg_rd) begin
			flag_clr = flag_view;
		end
		// a clear in the cycle of a new event must not lose that event
		// hold until cleared; set beats clear
		flag_next = (flag_reg & ~flag_clr) | flag_set;
	end

	// disabling an enable hides its flag but does not erase it
	// disabled source reads zero
	assign flag_view[`CSIC_DET_BIT] = flag_reg[`CSIC_DET_BIT] & source_enable[`CSIC_DET_BIT];
	assign flag_view[`CSIC_RDY_BIT] = flag_reg[`CSIC_RDY_BIT] &
		source_enable[`CSIC_RDY_BIT] & ~io_kind;
	assign flag_view[`CSIC_LOW_BIT] = flag_reg[`CSIC_LOW_BIT] &
		source_enable[`CSIC_LOW_BIT] & ~io_kind;
	assign flag_view[`CSIC_DEAD_BIT] = source_enable[`CSIC_DEAD_BIT] &
		((io_kind & ring_en) ? ring_active : flag_reg[`CSIC_DEAD_BIT]);

	// ----------------------------------------
	// control write
	// ----------------------------------------
	always @* begin
		ctrl_next = ctrl_reg;
		if (reg_wr && ctrl_hit) begin
			ctrl_next = reg_wdata;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= `CSIC_CTRL_RST;
			flag_reg <= `CSIC_STAT_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			flag_reg <= flag_next;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	reg [7:0] rdata_next;

	always @* begin
		rdata_next = 8'h00;
		if (ctrl_hit) begin
			rdata_next = ctrl_reg;
		end else if (stat_hit) begin
			rdata_next = {4'h0, flag_view};
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			// data holds between reads; rvalid marks the fresh byte
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// ----------------------------------------
	// interrupt routing
	// ----------------------------------------
	wire status_pending;
	wire to_pci;
	wire io_req;
	wire [15:0] status_vec;
	wire [15:0] io_vec;

	assign status_pending = |flag_view;
	// select zero also routes to pci
	// code zero keeps older drivers, which never set the route bit, working
	assign to_pci = ctrl_reg[`CSIC_PCI_ROUTE_BIT] | (io_sel == `CSIC_SEL_NONE);
	assign status_vec = line_decode(status_irq_line_select, status_pending & ~to_pci);
	// functional interrupt only for I/O card
	// I/O interrupt line select
	// level request, not latched: the card holds it until serviced
	assign io_req = io_kind & ~pin_sync_reg[5];
	assign io_vec = line_decode(io_sel, io_req);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			card_reset <= 1'b1;
			status_pci_irq <= 1'b0;
			status_legacy_irq <= 16'h0000;
			io_card_irq <= 16'h0000;
			system_mgmt_interrupt <= 1'b0;
		end else begin
			// reset held until bit set
			// next value, so the pin follows the write edge with no extra cycle
			card_reset <= ~ctrl_next[`CSIC_RST_REL_BIT];
			status_pci_irq <= status_pending & to_pci;
			// the SYSTEM_MGMT_INTERRUPT slot of the vectors is never driven; it has its own pin
			status_legacy_irq <= status_vec & ~`CSIC_SMI_MASK;
			io_card_irq <= io_vec & ~`CSIC_SMI_MASK;
			system_mgmt_interrupt <= status_vec[`CSIC_SEL_SMI] | io_vec[`CSIC_SEL_SMI];
		end
	end

endmodule // csic_top

// *** verification/csic_props.sv ***
`timescale 1ns/100ps
module csic_props (
	input wire clk,
	input wire rstn,
	input wire reg_wr,
	input wire reg_rd,
	input wire reg_rvalid,
	input wire card_irq_n,
	input wire card_reset,
	input wire status_pci_irq,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire [3:0] source_enable,
	input wire [15:0] status_legacy_irq,
	input wire [15:0] io_card_irq
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
property p_rvalid; reg_rd |=> reg_rvalid; endproperty
a_rvalid: assert property (p_rvalid) else $error("read not answered");
property p_rsvd; reg_rd && reg_addr == 8'h04 |=> reg_rdata[7:4] == 4'h0; endproperty
a_rsvd: assert property (p_rsvd) else $error("upper status bits set");
property p_crst; reg_wr && reg_addr == 8'h03 |=> card_reset == !$past(reg_wdata[6]); endproperty
a_crst: assert property (p_crst) else $error("card reset wrong");
property p_mask; reg_rd && reg_addr == 8'h04 && !source_enable[3] |=> !reg_rdata[3]; endproperty
a_mask: assert property (p_mask) else $error("disabled flag visible");
property p_no2; status_legacy_irq[2] == 1'b0 && io_card_irq[2] == 1'b0; endproperty
a_no2: assert property (p_no2) else $error("line two used");
property p_hot; $onehot0(status_legacy_irq) && $onehot0(io_card_irq); endproperty
a_hot: assert property (p_hot) else $error("several lines");
property p_ioq; card_irq_n [*5] |-> io_card_irq == 16'h0000; endproperty
a_ioq: assert property (p_ioq) else $error("io irq without request");
property p_off; source_enable == 4'h0 [*3] |-> !status_pci_irq && status_legacy_irq == 16'h0000;
endproperty
a_off: assert property (p_off) else $error("irq with sources off");
endmodule // csic_props

// *** verification/csic_card.sv ***
`timescale 1ns/100ps
module csic_card (
	output reg cd1_n,
	output reg cd2_n,
	output reg ready,
	output reg bvd1,
	output reg bvd2,
	output reg irq_n
);
// card starts outside the socket: pins idle high, battery good
initial {cd1_n, cd2_n, ready, bvd1, bvd2, irq_n} = 6'h3F;
endmodule // csic_card

// *** verification/card_socket_irq_status_control_bench.sv ***
`timescale 1ns/100ps
module card_socket_irq_status_control_bench;
reg clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, clear_by_write = 0;
reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
reg [3:0] source_enable = 4'h0, status_irq_line_select = 4'h3, fl = 4'h0;
wire [7:0] reg_rdata;
wire reg_rvalid, card_reset, status_pci_irq, system_mgmt_interrupt;
wire [15:0] status_legacy_irq, io_card_irq;
wire cd1_n, cd2_n, ready, bvd1, bvd2, irq_n;
integer n_errors = 0, n_tests = 0, seed = 32'h7992B1B1;
always #2.5 clk = ~clk;
csic_card card (.cd1_n(cd1_n), .cd2_n(cd2_n), .ready(ready), .bvd1(bvd1), .bvd2(bvd2),
	.irq_n(irq_n));
csic_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.source_enable(source_enable), .status_irq_line_select(status_irq_line_select),
	.clear_by_write(clear_by_write), .detect_pin_one_n(cd1_n), .detect_pin_two_n(cd2_n),
	.ready_pin(ready), .battery_detect1_ring_pin(bvd1), .battery_detect2_pin(bvd2),
	.card_irq_n(irq_n), .card_reset(card_reset), .status_pci_irq(status_pci_irq),
	.status_legacy_irq(status_legacy_irq), .io_card_irq(io_card_irq),
	.system_mgmt_interrupt(system_mgmt_interrupt));
task summarize;
	$display("tests %0d mismatches %0d", n_tests, n_errors);
	if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
	n_tests = n_tests + 1;
	if (s !== e) begin
		n_errors = n_errors + 1;
		$display("mismatch %s expected %h seen %h", nm, e, s);
	end
endtask
task w(input int n);
	repeat (n) @(negedge clk);
endtask
task wr(input logic [7:0] a, input logic [7:0] v);
	w(1);
	reg_addr = a;
	reg_wdata = v;
	reg_wr = 1;
	w(1);
	reg_wr = 0;
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
	w(1);
	reg_addr = a;
	reg_rd = 1;
	w(1);
	reg_rd = 0;
	chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
endtask
// ----------------------------------------
// reference flags: read clear drops only what the read showed
// ----------------------------------------
task rs;
	rd(8'h04, {4'h0, fl & source_enable});
	if (!clear_by_write) fl = fl & ~source_enable;
endtask
task ev(input logic [3:0] f);
	w(8);
	fl = fl | (f & source_enable);
endtask
initial begin
	repeat (20000) @(posedge clk);
	n_errors = n_errors + 1;
	summarize;
end
initial begin
	w(12);
	rstn = 1;
	rd(8'h03, 8'h00);
	rd(8'h04, 8'h00);
	chk("card_reset", card_reset, 1);
	rd(8'h07, 8'h00);
	repeat (4) begin
		d = $random(seed);
		wr(8'h03, d);
		rd(8'h03, d);
		chk("card_reset", card_reset, !d[6]);
	end
	$display("test control done");
	wr(8'h03, 8'h40);
	source_enable = 4'hF;
	card.cd1_n = 0;
	card.cd2_n = 0;
	ev(8);
	chk("pci", status_pci_irq, 1);
	rs;
	card.ready = 0;
	w(4);
	card.ready = 1;
	ev(4);
	card.bvd1 = 0;
	ev(2);
	card.bvd2 = 0;
	ev(1);
	rs;
	rs;
	{card.bvd1, card.bvd2} = 2'h3;
	$display("test memory card done");
	clear_by_write = 1;
	card.ready = 0;
	w(4);
	card.ready = 1;
	ev(4);
	rs;
	wr(8'h04, 8'hFF);
	fl = 0;
	rs;
	source_enable = 4'h7;
	card.cd1_n = 1;
	ev(8);
	rs;
	chk("pci", status_pci_irq, 0);
	source_enable = 4'hF;
	rs;
	wr(8'h04, 8'h08);
	fl = 0;
	wr(8'h03, 8'h45);
	card.ready = 0;
	w(4);
	card.ready = 1;
	ev(4);
	chk("legacy", status_legacy_irq, 16'h0008);
	wr(8'h04, 8'h04);
	fl = 0;
	$display("test routing done");
	wr(8'h03, 8'h65);
	card.irq_n = 0;
	w(8);
	chk("io", io_card_irq, 16'h0020);
	wr(8'h03, 8'h62);
	w(4);
	chk("smi", system_mgmt_interrupt, 1);
	card.irq_n = 1;
	card.ready = 0;
	w(4);
	card.ready = 1;
	ev(0);
	rs;
	wr(8'h03, 8'hE2);
	card.bvd1 = 0;
	ev(1);
	rs;
	card.bvd1 = 1;
	fl = 0;
	w(8);
	rs;
	wr(8'h03, 8'h62);
	card.bvd1 = 0;
	ev(1);
	rs;
	wr(8'h04, 8'h01);
	fl = 0;
	card.bvd1 = 1;
	w(8);
	rs;
	$display("test io card done");
	card.cd2_n = 1;
	w(8);
	rstn = 0;
	w(2);
	rstn = 1;
	fl = 0;
	rd(8'h03, 8'h00);
	rd(8'h04, 8'h00);
	chk("card_reset", card_reset, 1);
	$display("test reset done");
	summarize;
end
endmodule // card_socket_irq_status_control_bench
bind csic_top csic_props chk (.*);
